// *** hw/acc_clk_div.sv ***
// Converter clock enable divider
`timescale 1ns/10ps
module acc_clk_div #(
    parameter int DIV = 4
) (
    input  wire logic clk_sys_in,
    input  wire logic sys_rst_in,
    input  wire logic clear_in,
    output logic      tick_out
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt;

    // Free count; clear aligns ticks to a fresh conversion
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt <= '0;
        end else if (clear_in || cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign tick_out = (cnt == LAST);

    a_tick_gap: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        tick_out |=> !tick_out [*3])
        else $error("converter tick closer than four cycles");
endmodule

// *** hw/acc_ctrl_top.sv ***
// Continuous converter control: registers, sequencer, halt settling
`timescale 1ns/10ps
module acc_ctrl_top #(
    parameter int STAB_TIME_NS = 10000
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 sys_rst_in,
    input  wire acc_pkg::acc_bus_req_t bus_in,
    output logic [7:0]                rdata_out,
    input  wire logic                 halt_in,
    input  wire logic                 cmp_in,
    output acc_pkg::acc_analog_t      analog_out,
    output logic                      settled_out,
    output logic                      irq_out
);
    //**************************************************************
    // Constants
    //**************************************************************
    localparam int STAB_CYCLES =
        (STAB_TIME_NS + acc_pkg::CLK_PERIOD_NS - 1)
        / acc_pkg::CLK_PERIOD_NS;
    localparam logic [15:0] STAB_LOAD = 16'(STAB_CYCLES);
    localparam logic [3:0] PH_LAST =
        4'(acc_pkg::CONV_TICKS - 1);
    localparam logic [3:0] PH_LOAD_END =
        4'(acc_pkg::LOAD_TICKS - 1);
    localparam int CONV_LAST_CYC =
        acc_pkg::CONV_TICKS * acc_pkg::CPU_PER_ADC - 1;

    //**************************************************************
    // Declarations
    //**************************************************************
    acc_pkg::acc_state_t state;
    logic [3:0]  phase;
    logic        conv_on;
    logic [3:0]  chan;
    logic        done_flag;
    logic [acc_pkg::IRQ_W-1:0] irq_st;
    logic [acc_pkg::IRQ_W-1:0] irq_en;
    logic [acc_pkg::IRQ_W-1:0] irq_evt;
    logic [15:0] settle_cnt;
    logic        halt_q;
    logic        cmp_s1;
    logic        cmp_s2;
    logic        cmp_s3;
    logic        cmp_held;
    logic        cmp_now;
    logic        tick;
    logic        div_clear;
    logic        ctrl_wr;
    logic        res_rd;
    logic        restart;
    logic        abort;
    logic        conv_end;
    logic        sar_init;
    logic        sar_step;
    logic        wake;
    logic [7:0]  trial;
    logic [7:0]  result;
    logic [5:0]  since;

    //**************************************************************
    // Bus decode
    //**************************************************************
    function automatic logic hit(input acc_pkg::acc_bus_req_t r,
                                 input logic [7:0] ofs);
        hit = (r.addr == ofs);
    endfunction

    // Strobe qualifiers used by several processes
    assign ctrl_wr = bus_in.wr && hit(bus_in, acc_pkg::OFS_CTRL);
    assign res_rd  = bus_in.rd && hit(bus_in, acc_pkg::OFS_RESULT);
    assign restart = ctrl_wr && bus_in.wdata[acc_pkg::CTRL_ON_BIT]
                     && !halt_in;
    // Halt or any control write kills the conversion in flight
    assign abort   = ctrl_wr || halt_in;

    //**************************************************************
    // Comparator synchroniser
    //**************************************************************
    // Three stages; second and third must agree before use
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            cmp_s3 <= 1'b0;
        end else begin
            cmp_s1 <= cmp_in;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
        end
    end

    // Last agreed level, held through disagreement
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmp_held <= 1'b0;
        end else if (cmp_s2 == cmp_s3) begin
            cmp_held <= cmp_s3;
        end
    end

    assign cmp_now = (cmp_s2 == cmp_s3) ? cmp_s3 : cmp_held;

    //**************************************************************
    // Control register
    //**************************************************************
    // Flag bit and reserved bits are never stored from a write
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            conv_on <= 1'b0;
            chan    <= acc_pkg::CHAN_RST;
        end else if (ctrl_wr) begin
            conv_on <= bus_in.wdata[acc_pkg::CTRL_ON_BIT];
            chan    <= bus_in.wdata[acc_pkg::CHAN_W-1:0];
        end
    end

    //**************************************************************
    // Sequencer
    //**************************************************************
    // Divider held while off so each run starts on a clean tick
    assign div_clear = restart || (state == acc_pkg::ST_OFF);

    acc_clk_div #(
        .DIV (acc_pkg::CPU_PER_ADC)
    ) u_div (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .clear_in   (div_clear),
        .tick_out   (tick)
    );

    assign conv_end = (state == acc_pkg::ST_CONVERT) && tick
                      && phase == PH_LAST && !abort;
    assign sar_init = (state == acc_pkg::ST_LOAD) && tick
                      && phase == PH_LOAD_END && !abort;
    assign sar_step = (state == acc_pkg::ST_CONVERT) && tick
                      && !abort;

    // Load ticks then approximation ticks, wrapping while on
    // Only halt gates the run; wait mode is not seen here
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= acc_pkg::ST_OFF;
            phase <= 4'h0;
        end else if (halt_in || (ctrl_wr && !restart)) begin
            state <= acc_pkg::ST_OFF;
            phase <= 4'h0;
        end else if (restart) begin
            state <= acc_pkg::ST_LOAD;
            phase <= 4'h0;
        end else if (state == acc_pkg::ST_OFF) begin
            if (conv_on) begin
                state <= acc_pkg::ST_LOAD;
            end
            phase <= 4'h0;
        end else if (tick) begin
            if (phase == PH_LAST) begin
                state <= acc_pkg::ST_LOAD;
                phase <= 4'h0;
            end else begin
                phase <= phase + 4'h1;
                if (phase == PH_LOAD_END) begin
                    state <= acc_pkg::ST_CONVERT;
                end
            end
        end
    end

    acc_sar_step #(
        .BITS (acc_pkg::SAR_BITS)
    ) u_sar (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .init_in    (sar_init),
        .step_in    (sar_step),
        .cmp_in     (cmp_now),
        .trial_out  (trial),
        .result_out (result)
    );

    //**************************************************************
    // Done flag
    //**************************************************************
    // A finishing conversion beats a same-cycle result read
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            done_flag <= 1'b0;
        end else if (conv_end) begin
            done_flag <= 1'b1;
        end else if (ctrl_wr || res_rd) begin
            done_flag <= 1'b0;
        end
    end

    //**************************************************************
    // Halt wake settling
    //**************************************************************
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= halt_in;
        end
    end

    assign wake = halt_q && !halt_in;

    // Results taken before this runs out may be inaccurate
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            settle_cnt <= 16'h0000;
        end else if (wake) begin
            settle_cnt <= STAB_LOAD;
        end else if (settle_cnt != 16'h0000 && !halt_in) begin
            settle_cnt <= settle_cnt - 16'h0001;
        end
    end

    assign settled_out = (settle_cnt == 16'h0000) && !halt_in;

    //**************************************************************
    // Interrupts
    //**************************************************************
    // Conversion end itself never requests; only these two do
    always_comb begin
        irq_evt = '0;
        irq_evt[acc_pkg::IRQ_OVERRUN] = conv_end && done_flag
                                        && !res_rd;
        irq_evt[acc_pkg::IRQ_SETTLED] = settle_cnt == 16'h0001
                                        && !halt_in && !wake;
    end

    // Set beats clear in the same cycle
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_st <= '0;
        end else if (bus_in.wr
                     && hit(bus_in, acc_pkg::OFS_IRQ_CLR)) begin
            irq_st <= (irq_st & ~bus_in.wdata[acc_pkg::IRQ_W-1:0])
                      | irq_evt;
        end else begin
            irq_st <= irq_st | irq_evt;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_en <= '0;
        end else if (bus_in.wr && hit(bus_in, acc_pkg::OFS_IRQ_EN)) begin
            irq_en <= bus_in.wdata[acc_pkg::IRQ_W-1:0];
        end
    end

    assign irq_out = |(irq_st & irq_en);

    //**************************************************************
    // Read port
    //**************************************************************
    // Data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= 8'h00;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                acc_pkg::OFS_RESULT: begin
                    rdata_out <= result;
                end
                acc_pkg::OFS_CTRL: begin
                    rdata_out <= {done_flag, 1'b0, conv_on, 1'b0,
                                  chan};
                end
                acc_pkg::OFS_IRQ_ST: begin
                    rdata_out <= {6'h00, irq_st};
                end
                acc_pkg::OFS_IRQ_EN: begin
                    rdata_out <= {6'h00, irq_en};
                end
                default: begin
                    rdata_out <= 8'h00;
                end
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    //**************************************************************
    // Analog side
    //**************************************************************
    // Pins stay digital inputs too; nothing here drives them
    assign analog_out.powered = (state != acc_pkg::ST_OFF);
    assign analog_out.sample  = (state == acc_pkg::ST_LOAD);
    assign analog_out.channel = chan;
    assign analog_out.trial   = trial;

    //**************************************************************
    // Checks
    //**************************************************************
    // Cycles since the current conversion began
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            since <= 6'h00;
        end else if (div_clear || conv_end || abort) begin
            since <= 6'h00;
        end else if (since != 6'h3F) begin
            since <= since + 6'h01;
        end
    end

    a_conv_length: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        conv_end |-> since == 6'(CONV_LAST_CYC))
        else $error("conversion not 48 cycles long");

    a_done_set: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        conv_end |=> done_flag)
        else $error("done flag not set at conversion end");

    a_result_hold: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        !conv_end |=> $stable(result))
        else $error("result moved without conversion end");

    a_write_abort: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        restart |=> state == acc_pkg::ST_LOAD && phase == 4'h0
                    && !done_flag)
        else $error("control write did not restart");

    a_read_clears: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        res_rd && !conv_end |=> !done_flag)
        else $error("result read left flag set");

    a_halt_stops: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        halt_in |=> state == acc_pkg::ST_OFF && !analog_out.powered)
        else $error("converter running in halt");

    a_runs_on: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        conv_end && !bus_in.wr ##1 !halt_in && !bus_in.wr
        |-> state == acc_pkg::ST_LOAD && phase == 4'h0)
        else $error("conversion did not repeat");

    a_reserved_zero: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        bus_in.rd && hit(bus_in, acc_pkg::OFS_CTRL)
        |=> rdata_out[6] == 1'b0 && rdata_out[4] == 1'b0)
        else $error("reserved control bit read as one");

    a_settle_wait: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        wake |=> !settled_out)
        else $error("settled right after wake");
endmodule

// *** hw/acc_pkg.sv ***
// Constants and types for the continuous converter control block
//******************************************************************
//******************************************************************
package acc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_RESULT  = 8'h12;
    localparam logic [7:0] OFS_CTRL    = 8'h13;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h15;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h16;
    // Control field positions
    localparam int CTRL_DONE_BIT = 7;
    localparam int CTRL_ON_BIT   = 5;
    localparam int CHAN_W        = 4;
    // Interrupt status bit positions
    localparam int IRQ_OVERRUN   = 0;
    localparam int IRQ_SETTLED   = 1;
    localparam int IRQ_W         = 2;
    // Reset values
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [3:0] CHAN_RST   = 4'h0;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int CPU_PER_ADC   = 4;
    localparam int LOAD_TICKS    = 4;
    localparam int SAR_BITS      = 8;
    localparam int CONV_TICKS    = LOAD_TICKS + SAR_BITS;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_LOAD,
        ST_CONVERT
    } acc_state_t;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acc_bus_req_t;

    // Drive toward the analog front end
    typedef struct packed {
        logic        powered;
        logic        sample;
        logic [3:0]  channel;
        logic [7:0]  trial;
    } acc_analog_t;
endpackage

// *** hw/acc_sar_step.sv ***
// Successive approximation step register and result holder
`timescale 1ns/10ps
module acc_sar_step #(
    parameter int BITS = 8
) (
    input  wire logic            clk_sys_in,
    input  wire logic            sys_rst_in,
    input  wire logic            init_in,
    input  wire logic            step_in,
    input  wire logic            cmp_in,
    output logic [BITS-1:0]      trial_out,
    output logic [BITS-1:0]      result_out
);
    localparam logic [BITS-1:0] TOP = {1'b1, {(BITS-1){1'b0}}};

    logic [BITS-1:0] approx;
    logic [BITS-1:0] mask;
    logic [BITS-1:0] next_code;

    // Keep the trial bit only if the input reached it
    always_comb begin
        next_code = cmp_in ? approx : (approx & ~mask);
    end

    // One bit per step, most significant first
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            approx <= '0;
            mask   <= '0;
        end else if (init_in) begin
            approx <= TOP;
            mask   <= TOP;
        end else if (step_in && mask != '0) begin
            approx <= next_code | (mask >> 1);
            mask   <= mask >> 1;
        end
    end

    // Result moves only on the final step
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            result_out <= '0;
        end else if (step_in && mask[0]) begin
            result_out <= next_code;
        end
    end

    assign trial_out = approx;

    a_mask_onehot: assert property (
        @(posedge clk_sys_in) disable iff (sys_rst_in)
        $onehot0(mask))
        else $error("approximation mask not one-hot");
endmodule

// *** testbench/acc_front_model.sv ***
// Behavioural analog front end: sample capacitor and comparator
`timescale 1ns/10ps
module acc_front_model (
    input  wire logic                 clk_sys_in,
    input  wire acc_pkg::acc_analog_t analog_in,
    input  wire logic [127:0]         levels_in,
    output logic                      cmp_out
);
    logic [7:0] held = 8'h00;
    logic       flip = 1'b0;

    // Capacitor follows the picked pin only during the load phase
    always_ff @(posedge clk_sys_in) begin
        flip <= ~flip;
        if (analog_in.powered && analog_in.sample) begin
            held <= levels_in[analog_in.channel*8 +: 8];
        end
    end

    // Unpowered comparator gives noise, so a stale level never helps
    always_comb begin
        if (analog_in.powered) begin
            cmp_out = (held >= analog_in.trial);
        end else begin
            cmp_out = flip;
        end
    end
endmodule

// *** testbench/tb_acc_ctrl_top.sv ***
// Self-checking bench for the continuous converter control block
`timescale 1ns/10ps
module tb_acc_ctrl_top;
    logic                  clk_sys_in   = 1'b0;
    logic                  sys_rst_in   = 1'b1;
    acc_pkg::acc_bus_req_t bus_in       = '0;
    logic                  halt_in      = 1'b0;
    logic [7:0]            rdata_out;
    logic                  cmp_in;
    acc_pkg::acc_analog_t  analog_out;
    logic                  settled_out;
    logic                  irq_out;
    logic [127:0]          levels       = '0;
    logic [7:0]            lv;
    logic [3:0]            ch;
    int                    error_cnt    = 0;
    int                    total_checks = 0;

    // 25 MHz clock
    always #20 clk_sys_in = ~clk_sys_in;

    // Short settling time keeps the halt scenario brief
    acc_ctrl_top #(.STAB_TIME_NS(200)) dut (
        .clk_sys_in  (clk_sys_in),
        .sys_rst_in  (sys_rst_in),
        .bus_in      (bus_in),
        .rdata_out   (rdata_out),
        .halt_in     (halt_in),
        .cmp_in      (cmp_in),
        .analog_out  (analog_out),
        .settled_out (settled_out),
        .irq_out     (irq_out)
    );

    acc_front_model model (
        .clk_sys_in (clk_sys_in),
        .analog_in  (analog_out),
        .levels_in  (levels),
        .cmp_out    (cmp_in)
    );

    //**************************************************************
    // Helpers
    //**************************************************************
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    // One-cycle write strobe; caller always sees a gap before the next
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        bus_in.wr    <= 1'b1;
        bus_in.addr  <= a;
        bus_in.wdata <= d;
        @(posedge clk_sys_in);
        bus_in.wr    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
        @(posedge clk_sys_in);
        bus_in.rd   <= 1'b1;
        bus_in.addr <= a;
        @(posedge clk_sys_in);
        bus_in.rd   <= 1'b0;
        #1;
        check(what, rdata_out, exp);
    endtask

    // Successive approximation against a held level, MSB first
    function automatic logic [7:0] sar(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            if (v >= (r | (8'h01 << b))) begin
                r = r | (8'h01 << b);
            end
        end
        return r;
    endfunction

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 600 cycles
    initial begin
        wait_cyc(6000);
        error_cnt++;
        conclude();
    end

    //**************************************************************
    // Main sequence
    //**************************************************************
    initial begin
        void'($urandom(32'hB67B665D));
        wait_cyc(4);
        sys_rst_in <= 1'b0;
        rd_chk("result rst", acc_pkg::OFS_RESULT, 8'h00);
        rd_chk("ctrl rst", acc_pkg::OFS_CTRL, 8'h00);
        rd_chk("unmapped", 8'h20, 8'h00);
        // Corner channels and levels first, then random pairs
        for (int i = 0; i < 6; i++) begin
            ch = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            lv = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            levels[ch*8 +: 8] = lv;
            reg_wr(acc_pkg::OFS_CTRL, {4'hF, ch});
            #1;
            check("powered", analog_out.powered, 1'b1);
            check("sample on", analog_out.sample, 1'b1);
            check("channel", analog_out.channel, ch);
            wait_cyc(16);
            #1;
            check("load end", analog_out.sample, 1'b0);
            check("first trial", analog_out.trial, 8'h80);
            wait_cyc(31);
            #1;
            check("conv late", analog_out.sample, 1'b0);
            wait_cyc(1);
            #1;
            check("reload", analog_out.sample, 1'b1);
            rd_chk("ctrl done", acc_pkg::OFS_CTRL, {4'hA, ch});
            rd_chk("result", acc_pkg::OFS_RESULT, sar(lv));
            rd_chk("ctrl clr", acc_pkg::OFS_CTRL, {4'h2, ch});
            check("no irq", irq_out, 1'b0);
        end
        // Rewrite in mid-conversion aborts the pending end
        wait_cyc(30);
        reg_wr(acc_pkg::OFS_CTRL, {4'h2, ch});
        wait_cyc(20);
        rd_chk("abort", acc_pkg::OFS_CTRL, {4'h2, ch});
        wait_cyc(30);
        rd_chk("restart", acc_pkg::OFS_CTRL, {4'hA, ch});
        // Result holds through a level change until the next end
        rd_chk("rd clr", acc_pkg::OFS_RESULT, sar(lv));
        rd_chk("flag off", acc_pkg::OFS_CTRL, {4'h2, ch});
        levels[ch*8 +: 8] = ~lv;
        wait_cyc(20);
        rd_chk("held", acc_pkg::OFS_RESULT, sar(lv));
        wait_cyc(100);
        rd_chk("next", acc_pkg::OFS_RESULT, sar(~lv));
        reg_wr(acc_pkg::OFS_CTRL, 8'h00);
        wait_cyc(2);
        #1;
        check("off", analog_out.powered, 1'b0);
        rd_chk("ctrl off", acc_pkg::OFS_CTRL, 8'h00);
        // Second unread end while running on set the overrun bit
        rd_chk("overrun", acc_pkg::OFS_IRQ_ST, 8'h01);
        // Halt, settling event, masked then enabled interrupt
        reg_wr(acc_pkg::OFS_IRQ_CLR, 8'h03);
        reg_wr(acc_pkg::OFS_CTRL, 8'h23);
        wait_cyc(10);
        halt_in <= 1'b1;
        wait_cyc(3);
        #1;
        check("halt off", analog_out.powered, 1'b0);
        check("halt unsettled", settled_out, 1'b0);
        @(posedge clk_sys_in);
        halt_in <= 1'b0;
        wait_cyc(2);
        #1;
        check("settling", settled_out, 1'b0);
        check("rerun", analog_out.powered, 1'b1);
        wait_cyc(10);
        #1;
        check("settled", settled_out, 1'b1);
        check("masked", irq_out, 1'b0);
        rd_chk("status", acc_pkg::OFS_IRQ_ST, 8'h02);
        reg_wr(acc_pkg::OFS_IRQ_EN, 8'h02);
        #1;
        check("irq on", irq_out, 1'b1);
        rd_chk("enable", acc_pkg::OFS_IRQ_EN, 8'h02);
        reg_wr(acc_pkg::OFS_IRQ_CLR, 8'h02);
        #1;
        check("irq clr", irq_out, 1'b0);
        rd_chk("status clr", acc_pkg::OFS_IRQ_ST, 8'h00);
        conclude();
    end
endmodule
